//--- shared/fspm_pkg.sv
// Constants for the flash self-programming mode control block
package fspm_pkg;
   // Register index map (byte wide registers, one per address)
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  CMD_OFS       = 4'h0;
   localparam logic [3:0]  STAT_OFS      = 4'h1;
   localparam logic [3:0]  MODE_OFS      = 4'h2;
   // Mode control register fields
   localparam int          DIS_BIT       = 3;
   localparam int          VPP_BIT       = 2;
   localparam int          SEL_BIT       = 1;
   localparam logic [7:0]  MODE_RST      = 8'h08;
   localparam logic [7:0]  MODE_ABSENT   = 8'h00;
   localparam logic        DIS_RST       = 1'b1;
   localparam logic        SEL_RST       = 1'b0;
   // Status register fields
   localparam int          ERR_BIT       = 0;
   // Trap and parameter block
   localparam logic [4:0]  TRAP_VEC      = 5'h1f;
   localparam logic [31:0] NMI_FLAG_OFS  = 32'h0000_0004;
   localparam logic [2:0]  NMI_FLAG_BIT  = 3'h7;
   // Setup time after leaving self-programming
   localparam int          CLK_MHZ       = 250;
   localparam int          SETUP_US      = 100;
   localparam int          SETUP_CYC     = SETUP_US * CLK_MHZ;
   localparam int          SETUP_W       = 15;
   // Internal processing call sequence
   typedef enum logic [2:0] {
      FSPM_IDLE  = 3'b001,
      FSPM_ENTER = 3'b010,
      FSPM_RUN   = 3'b100
   } fspm_state_t;
endpackage

//--- src/fspm_capreg.sv
// Load-enabled capture register for call arguments and results
`timescale 1ns/100ps
`default_nettype none
module fspm_capreg #(
   parameter int W = 32
) (
   input  wire logic         sys_clk_i, // System clock
   input  wire logic         rstn_i,    // Async reset, active low
   input  wire logic         load_i,    // Capture strobe
   input  wire logic [W-1:0] d_i,       // Value to capture
   output logic      [W-1:0] q_o        // Held value
);
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q_o <= '0;
      end else if (load_i) begin
         q_o <= d_i;
      end
   end
endmodule
`default_nettype wire

//--- src/fspm_ctrl.sv
// Flash self-programming mode control with protected write and trap entry
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Mode register byte or bit-mask writable; voltage-detect bit 2 read-only
// - Reset reads 08H, 0CH with programming voltage, 00H without flash
// - Bit 3 set blocks all flash write and erase
// - Bit 2 reads 1 while programming voltage is detected
// - Bit 1 selects self-programming mode instead of normal fetch
// - Select bit honoured only while programming voltage is detected
// - External programmer mode ignores the select bit
// - Mode write only right after protect command write, else error
// - Mode register readable any time without unlock
// - Trap 1FH in self-programming mode enters internal processing
// - Otherwise trap 1FH is an ordinary software trap
// - Arguments taken from r6 to r9 and parameter base ep
// - Four-byte result returned in r10, nonzero means error
// - NMI during processing sets bit 7 at ep+4, never clears
// - NMI during the entry transfer may be lost
module fspm_ctrl
   import fspm_pkg::*;
#(
   parameter bit          FLASH_PRESENT = 1'b1,
   parameter int unsigned SETUP_CYCLES  = fspm_pkg::SETUP_CYC
) (
   input  wire logic                      sys_clk_i,    // System clock
   input  wire logic                      rstn_i,       // Async reset
   input  wire logic [fspm_pkg::ADDR_W-1:0] addr_i,     // Register index
   input  wire logic [7:0]                wdata_i,      // Write data
   input  wire logic [7:0]                wmask_i,      // Bits to write
   input  wire logic                      wr_i,         // Write strobe
   input  wire logic                      rd_i,         // Read strobe
   output logic      [7:0]                rdata_o,      // Read data
   input  wire logic                      vpp_detect_i, // Prog voltage ok
   input  wire logic                      onboard_i,    // Ext programmer
   input  wire logic                      irq_ack_i,    // Interrupt taken
   input  wire logic                      trap_i,       // Trap executed
   input  wire logic [4:0]                trap_code_i,  // Trap vector
   input  wire logic [31:0]               r6_i,         // Function number
   input  wire logic [31:0]               r7_i,         // Argument 2
   input  wire logic [31:0]               r8_i,         // Argument 3
   input  wire logic [31:0]               r9_i,         // Argument 4
   input  wire logic [31:0]               ep_i,         // Param block base
   input  wire logic                      nmi_i,        // NMI request
   input  wire logic                      proc_done_i,  // Routine returns
   input  wire logic [31:0]               proc_res_i,   // Routine result
   output logic                           wr_erase_en_o, // Program allowed
   output logic                           self_prog_o,  // Mode in force
   output logic                           flash_ready_o, // Setup elapsed
   output logic                           trap_int_o,   // Enter routine
   output logic                           trap_user_o,  // Ordinary trap
   output logic                           busy_o,       // Routine active
   output logic      [31:0]               fn_o,         // Latched r6
   output logic      [31:0]               arg7_o,       // Latched r7
   output logic      [31:0]               arg8_o,       // Latched r8
   output logic      [31:0]               arg9_o,       // Latched r9
   output logic      [31:0]               ep_o,         // Latched ep
   output logic      [31:0]               result_o,     // r10 result
   output logic                           result_err_o, // Result nonzero
   output logic                           nmi_flag_wr_o, // Set flag pulse
   output logic      [31:0]               nmi_flag_addr_o, // ep+4
   output logic      [2:0]                nmi_flag_bit_o   // Flag bit
);
   import fspm_pkg::*;

   logic        dis_reg;
   logic        sel_reg;
   logic        vpp_reg;
   logic        armed_reg;
   logic        err_reg;
   logic [7:0]  mode_view;
   logic        mode_wr;
   logic        mode_ok;
   logic        sp_next;
   logic        enter;
   logic        done;
   logic        nmi_seen_reg;
   logic [SETUP_W-1:0] setup_cnt_reg;
   fspm_state_t state_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Register access
   assign mode_wr = wr_i && (addr_i == MODE_OFS);
   assign mode_ok = mode_wr && armed_reg && !irq_ack_i && FLASH_PRESENT;
   // live voltage bit, reset image follows it
   assign mode_view = FLASH_PRESENT ?
      {4'h0, dis_reg, vpp_reg, sel_reg, 1'b0} : MODE_ABSENT;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vpp_reg <= 1'b0;
      end else begin
         vpp_reg <= vpp_detect_i;
      end
   end

   // Any access other than another command write, or an interrupt, between unlock and mode write spoils it
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         armed_reg <= 1'b0;
      end else if (wr_i && addr_i == CMD_OFS) begin
         armed_reg <= 1'b1;
      end else if (wr_i || rd_i || irq_ack_i) begin
         armed_reg <= 1'b0;
      end
   end

   // masked write, bit 2 not stored
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dis_reg <= DIS_RST;
         sel_reg <= SEL_RST;
      end else if (mode_ok) begin
         if (wmask_i[DIS_BIT]) begin
            dis_reg <= wdata_i[DIS_BIT];
         end
         if (wmask_i[SEL_BIT]) begin
            sel_reg <= wdata_i[SEL_BIT];
         end
      end
   end

   // sticky error, set wins over clear
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         err_reg <= 1'b0;
      end else if (mode_wr && !mode_ok) begin
         err_reg <= 1'b1;
      end else if (wr_i && addr_i == STAT_OFS && wmask_i[ERR_BIT]
                   && !wdata_i[ERR_BIT]) begin
         err_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            MODE_OFS: rdata_o <= mode_view;
            STAT_OFS: rdata_o <= {7'h00, err_reg};
            default:  rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   // select gated by voltage and programmer mode
   assign sp_next = sel_reg && vpp_reg && !onboard_i && FLASH_PRESENT;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         self_prog_o   <= 1'b0;
         wr_erase_en_o <= 1'b0;
      end else begin
         self_prog_o   <= sp_next;
         wr_erase_en_o <= !dis_reg && vpp_reg && FLASH_PRESENT;
      end
   end

   // flash held off for the setup time after leaving the mode
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         setup_cnt_reg <= '0;
         flash_ready_o <= 1'b1;
      end else if (self_prog_o && !sp_next) begin
         setup_cnt_reg <= SETUP_W'(SETUP_CYCLES);
         flash_ready_o <= 1'b0;
      end else if (sp_next) begin
         setup_cnt_reg <= '0;
         flash_ready_o <= 1'b0;
      end else if (setup_cnt_reg != '0) begin
         setup_cnt_reg <= setup_cnt_reg - SETUP_W'(1);
         flash_ready_o <= (setup_cnt_reg == SETUP_W'(1));
      end else begin
         flash_ready_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trap entry and internal processing
   // trap routing
   assign enter = trap_i && trap_code_i == TRAP_VEC && self_prog_o
                  && state_reg == FSPM_IDLE;
   assign done  = proc_done_i && state_reg == FSPM_RUN;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= FSPM_IDLE;
      end else begin
         unique case (state_reg)
            FSPM_IDLE:  if (enter) state_reg <= FSPM_ENTER;
            FSPM_ENTER: state_reg <= FSPM_RUN;
            FSPM_RUN:   if (proc_done_i) state_reg <= FSPM_IDLE;
            default:    state_reg <= FSPM_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trap_int_o  <= 1'b0;
         trap_user_o <= 1'b0;
         busy_o      <= 1'b0;
      end else begin
         trap_int_o  <= enter;
         trap_user_o <= trap_i && !enter;
         busy_o      <= (state_reg != FSPM_IDLE || enter) && !done;
      end
   end

   // an NMI in the entry cycle is not recorded
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nmi_seen_reg <= 1'b0;
      end else if (enter || done) begin
         nmi_seen_reg <= 1'b0;
      end else if (state_reg == FSPM_RUN && nmi_i) begin
         nmi_seen_reg <= 1'b1;
      end
   end

   // flag write only sets the bit, never clears it
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nmi_flag_wr_o  <= 1'b0;
         nmi_flag_bit_o <= NMI_FLAG_BIT;
         result_err_o   <= 1'b0;
      end else begin
         nmi_flag_wr_o  <= done && (nmi_seen_reg || nmi_i);
         nmi_flag_bit_o <= NMI_FLAG_BIT;
         if (done) begin
            result_err_o <= proc_res_i != 32'h0000_0000;
         end
      end
   end

   fspm_capreg #(.W(32)) u_r6  (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(enter), .d_i(r6_i), .q_o(fn_o));
   fspm_capreg #(.W(32)) u_r7  (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(enter), .d_i(r7_i), .q_o(arg7_o));
   fspm_capreg #(.W(32)) u_r8  (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(enter), .d_i(r8_i), .q_o(arg8_o));
   fspm_capreg #(.W(32)) u_r9  (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(enter), .d_i(r9_i), .q_o(arg9_o));
   fspm_capreg #(.W(32)) u_ep  (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(enter), .d_i(ep_i), .q_o(ep_o));
   fspm_capreg #(.W(32)) u_flg (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(enter), .d_i(ep_i + NMI_FLAG_OFS), .q_o(nmi_flag_addr_o));
   fspm_capreg #(.W(32)) u_r10 (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .load_i(done), .d_i(proc_res_i), .q_o(result_o));

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   vpp_read_a: assert property (
      rd_i && addr_i == MODE_OFS && FLASH_PRESENT
      |=> rdata_o[VPP_BIT] == $past(vpp_reg))
      else $error("voltage bit read wrong");
   mode_read_a: assert property (
      rd_i && addr_i == MODE_OFS |=> rdata_o == $past(mode_view))
      else $error("mode read data wrong");
   wr_block_a: assert property (
      dis_reg |=> !wr_erase_en_o)
      else $error("write enabled while disabled");
   sel_gate_a: assert property (
      !vpp_reg |=> !self_prog_o)
      else $error("mode without voltage");
   onboard_ign_a: assert property (
      onboard_i |=> !self_prog_o)
      else $error("mode in programmer mode");
   unlock_req_a: assert property (
      mode_wr && !armed_reg
      |=> err_reg && $stable(dis_reg) && $stable(sel_reg))
      else $error("unprotected mode write took effect");
   err_sticky_a: assert property (
      err_reg && !(wr_i && addr_i == STAT_OFS) |=> err_reg)
      else $error("error flag lost");
   trap_enter_a: assert property (
      enter |=> trap_int_o && !trap_user_o ##1 busy_o && fn_o == $past(r6_i, 2))
      else $error("internal entry failed");
   trap_plain_a: assert property (
      trap_i && !self_prog_o |=> trap_user_o && !trap_int_o)
      else $error("trap misrouted");
   nmi_flag_a: assert property (
      state_reg == FSPM_RUN && nmi_i |=> nmi_seen_reg || nmi_flag_wr_o)
      else $error("nmi not recorded");
   nmi_write_a: assert property (
      done && nmi_seen_reg |=> nmi_flag_wr_o)
      else $error("nmi flag not written");
   result_err_a: assert property (
      done |=> result_o == $past(proc_res_i)
               && result_err_o == ($past(proc_res_i) != 32'h0000_0000))
      else $error("result error mismatch");
   setup_wait_a: assert property (
      self_prog_o && !sp_next |=> !flash_ready_o [*8])
      else $error("flash ready too early");

   unlock_ok_c: cover property (mode_ok);
   reject_c:    cover property (mode_wr && !mode_ok);
   call_c:      cover property (enter ##[1:20] done);
   nmi_c:       cover property (nmi_flag_wr_o);
endmodule
`default_nettype wire

//--- tb/fspm_routine_model.sv
// Behavioural model of the internal processing routine behind the trap
`timescale 1ns/100ps
`default_nettype none
module fspm_routine_model (
   input  wire logic        sys_clk_i, // System clock
   input  wire logic        rstn_i,    // Async reset, active low
   input  wire logic        enter_i,   // Routine entered
   input  wire logic [3:0]  dly_i,     // Cycles of work
   input  wire logic [31:0] res_i,     // Result to hand back
   output logic             done_o,    // Return pulse
   output logic      [31:0] res_o      // Result, valid with done_o
);
   logic [4:0] cnt_reg;
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= 5'h00;
         done_o  <= 1'b0;
         res_o   <= 32'h0000_0000;
      end else begin
         done_o <= 1'b0;
         // Result lines toggle outside the return so stale data never match
         res_o  <= ~res_o;
         if (enter_i)
            cnt_reg <= {1'b0, dly_i} + 5'h01;
         else if (cnt_reg != 5'h00)
            cnt_reg <= cnt_reg - 5'h01;
         if (cnt_reg == 5'h01) begin
            done_o <= 1'b1;
            res_o  <= res_i;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/fspm_ctrl_tb_top.sv
// Self-checking bench for the flash self-programming mode control block
`timescale 1ns/100ps
`default_nettype none
module fspm_ctrl_tb_top;
   import fspm_pkg::*;
   localparam int unsigned SETUP = 10;
   logic              clk, rstn, wr, rd, vpp, onb, irq, trap, nmi, done;
   logic              wee, spo, rdy, tint, tusr, busy, rerr, nfwr;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wdata, wmask, rdata, last_rd;
   logic [4:0]        code;
   logic [3:0]        dly;
   logic [2:0]        nfbit;
   logic [31:0]       r6, r7, r8, r9, ep, rv, pres, res, fn, a7, a8, a9, epo;
   logic [31:0]       nfadr;
   int                n_errors, samples_checked;

   fspm_ctrl #(.FLASH_PRESENT(1'b1), .SETUP_CYCLES(SETUP)) dut_u (
      .sys_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
      .wmask_i(wmask), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .vpp_detect_i(vpp), .onboard_i(onb), .irq_ack_i(irq), .trap_i(trap),
      .trap_code_i(code), .r6_i(r6), .r7_i(r7), .r8_i(r8), .r9_i(r9),
      .ep_i(ep), .nmi_i(nmi), .proc_done_i(done), .proc_res_i(pres),
      .wr_erase_en_o(wee), .self_prog_o(spo), .flash_ready_o(rdy),
      .trap_int_o(tint), .trap_user_o(tusr), .busy_o(busy), .fn_o(fn),
      .arg7_o(a7), .arg8_o(a8), .arg9_o(a9), .ep_o(epo), .result_o(res),
      .result_err_o(rerr), .nmi_flag_wr_o(nfwr), .nmi_flag_addr_o(nfadr),
      .nmi_flag_bit_o(nfbit));
   fspm_routine_model mdl_u (.sys_clk_i(clk), .rstn_i(rstn),
      .enter_i(tint), .dly_i(dly), .res_i(rv), .done_o(done), .res_o(pres));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   // Values seen at an edge are those of the cycle just ended
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         last_rd = rdata;
      end
   endtask
   task automatic idle(input int n);
      wr  <= 1'b0;
      rd  <= 1'b0;
      irq <= 1'b0;
      cyc(n);
   endtask
   task automatic bus(input logic w, r, input logic [3:0] a,
                      input logic [7:0] d, m);
      wr    <= w;
      rd    <= r;
      addr  <= a;
      wdata <= d;
      wmask <= m;
      cyc(1);
   endtask
   task automatic rdc(input string nm, input logic [3:0] a,
                      input logic [7:0] e);
      bus(1'b0, 1'b1, a, 8'h00, 8'h00);
      idle(1);
      chk(nm, {24'h0, e}, {24'h0, last_rd});
   endtask
   // quiet unlock sequence
   // Dummy command uses the same data as the mode write
   task automatic pw(input logic [7:0] d, m);
      bus(1'b1, 1'b0, CMD_OFS, d, 8'hff);
      bus(1'b1, 1'b0, MODE_OFS, d, m);
      idle(5);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // reset state
   task automatic t_reset;
      chk("ready", 1, rdy);
      chk("wr_erase", 0, wee);
      rdc("mode", MODE_OFS, 8'h08);
      rdc("status", STAT_OFS, 8'h00);
      rdc("unmapped", 4'hf, 8'h00);
   endtask
   task automatic t_lock;
      pw(8'h0c, 8'hff);
      rdc("mode_ro", MODE_OFS, 8'h08);
      vpp <= 1'b1;
      idle(2);
      rdc("mode_vpp", MODE_OFS, 8'h0c);
      bus(1'b1, 1'b0, MODE_OFS, 8'h02, 8'hff);
      idle(1);
      rdc("mode_bare", MODE_OFS, 8'h0c);
      rdc("err_set", STAT_OFS, 8'h01);
      rdc("err_stick", STAT_OFS, 8'h01);
      bus(1'b1, 1'b0, STAT_OFS, 8'h00, 8'h01);
      rdc("err_clr", STAT_OFS, 8'h00);
      bus(1'b1, 1'b0, CMD_OFS, 8'h02, 8'hff);
      wr  <= 1'b0;
      irq <= 1'b1;
      cyc(1);
      irq <= 1'b0;
      bus(1'b1, 1'b0, MODE_OFS, 8'h02, 8'hff);
      idle(1);
      rdc("mode_irq", MODE_OFS, 8'h0c);
      rdc("err_irq", STAT_OFS, 8'h01);
      bus(1'b1, 1'b0, STAT_OFS, 8'h00, 8'h01);
      idle(1);
   endtask
   task automatic t_mode;
      pw(8'h02, 8'hff);
      rdc("mode_sp", MODE_OFS, 8'h06);
      chk("self_prog", 1, spo);
      chk("wr_erase", 1, wee);
      chk("ready_sp", 0, rdy);
      vpp <= 1'b0;
      idle(3);
      chk("sp_novpp", 0, spo);
      vpp <= 1'b1;
      onb <= 1'b1;
      idle(3);
      chk("sp_onboard", 0, spo);
      onb <= 1'b0;
      idle(3);
      chk("sp_back", 1, spo);
   endtask
   task automatic t_trap(input logic [4:0] c, input logic in,
                         input int nw, input logic [31:0] v);
      logic sawn;
      int   k;
      sawn = 1'b0;
      trap <= 1'b1;
      code <= c;
      r6   <= {27'h0, c};
      r7   <= 32'h7000_0007;
      r8   <= 32'h8000_0008;
      r9   <= 32'h9000_0009;
      ep   <= 32'h2000_0100;
      rv   <= v;
      dly  <= 4'h3;
      cyc(1);
      trap <= 1'b0;
      nmi  <= (nw == 1);
      cyc(1);
      nmi  <= (nw == 2);
      chk("trap_int", in, tint);
      chk("trap_user", !in, tusr);
      if (in) begin
         chk("busy", 1, busy);
         chk("fn", {27'h0, c}, fn);
         chk("arg7", 32'h7000_0007, a7);
         chk("arg8", 32'h8000_0008, a8);
         chk("arg9", 32'h9000_0009, a9);
         chk("ep", 32'h2000_0100, epo);
         chk("nmi_adr", 32'h2000_0104, nfadr);
         chk("nmi_bit", 3'h7, nfbit);
      end
      for (k = 0; k < 40 && busy === 1'b1; k++) begin
         cyc(1);
         nmi  <= 1'b0;
         sawn = sawn | (nfwr === 1'b1);
      end
      if (k == 40) begin
         n_errors++;
         end_sim();
      end
      if (in) begin
         chk("result", v, res);
         chk("res_err", v != 0, rerr);
         chk("nmi_flag", nw == 2, sawn);
      end
   endtask
   task automatic t_leave;
      int k;
      int n;
      n = 0;
      pw(8'h08, 8'h08);
      rdc("mode_bit", MODE_OFS, 8'h0e);
      chk("wee_dis", 0, wee);
      bus(1'b1, 1'b0, CMD_OFS, 8'h08, 8'hff);
      bus(1'b1, 1'b0, MODE_OFS, 8'h08, 8'hff);
      for (k = 0; k < 60 && rdy !== 1'b1; k++) begin
         idle(1);
         if (spo === 1'b0 && rdy === 1'b0)
            n++;
      end
      if (k == 60) begin
         n_errors++;
         end_sim();
      end
      // Ready rises SETUP cycles after the mode output drops
      chk("setup_len", SETUP, n);
      rdc("mode_out", MODE_OFS, 8'h0c);
   endtask
   // reset image with programming voltage present
   task automatic t_rst_vpp;
      rstn <= 1'b0;
      cyc(2);
      rstn <= 1'b1;
      idle(1);
      chk("rst_wee", 0, wee);
      chk("rst_sp", 0, spo);
      rdc("mode_rst", MODE_OFS, 8'h0c);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors = 0;
      samples_checked = 0;
      {rstn, wr, rd, vpp, onb, irq, trap, nmi} = 8'h00;
      {addr, wdata, wmask, code, dly} = '0;
      {r6, r7, r8, r9, ep, rv} = '0;
      cyc(5);
      rstn <= 1'b1;
      t_reset();
      t_lock();
      t_mode();
      t_trap(5'h1f, 1'b1, 2, 32'h0000_0000);
      t_trap(5'h1f, 1'b1, 1, 32'h0000_0005);
      t_trap(5'h1e, 1'b0, 0, 32'h0000_0000);
      t_leave();
      t_trap(5'h1f, 1'b0, 0, 32'h0000_0000);
      t_rst_vpp();
      end_sim();
   end
endmodule
`default_nettype wire
